// ==== core/sidb_dec_if.sv ====
// Carrier between the instruction latch and its decoder
`timescale 1ns/1ps
`default_nettype none
interface sidb_dec_if;
  import sidb_pkg::*;

  logic [7:0] instr;
  sidb_dreg_t dreg;
  sidb_mode_t mode;
  sidb_cap_t  cap;
  logic       drive_core;
  logic       drive_pins;
  logic       io_highz;
  logic       run_test;
  logic       toggle_out;
  logic       parity_ok;

  // Decoder side
  modport dec (
    input  instr,
    output dreg, mode, cap, drive_core, drive_pins, io_highz, run_test, toggle_out, parity_ok
  );

  // Latch side
  modport user (
    output instr,
    input  dreg, mode, cap, drive_core, drive_pins, io_highz, run_test, toggle_out, parity_ok
  );
endinterface
`default_nettype wire

// ==== core/sidb_instr_decoder.sv ====
// Opcode decoder from the latched instruction to selections and modes
`timescale 1ns/1ps
`default_nettype none
module sidb_instr_decoder
(
  sidb_dec_if.dec dec
);
  import sidb_pkg::*;

  // Table lookup; anything unlisted falls to bypass in normal mode
  always_comb
  begin
    dec.dreg       = SIDB_DR_BYPASS;
    dec.mode       = SIDB_MODE_NORMAL;
    dec.cap        = SIDB_CAP_HOLD;
    dec.io_highz   = 1'b0;
    dec.run_test   = 1'b0;
    dec.toggle_out = 1'b0;
    case (dec.instr)
      OP_BOUNDARY_EXT, OP_BOUNDARY_INT:
      begin
        dec.dreg = SIDB_DR_BOUNDARY;
        dec.mode = SIDB_MODE_TEST;
        dec.cap  = SIDB_CAP_PINS;
      end
      OP_SAMPLE:
      begin
        dec.dreg = SIDB_DR_BOUNDARY;
        dec.cap  = SIDB_CAP_PINS;
      end
      OP_READ_NORMAL: dec.dreg = SIDB_DR_BOUNDARY;
      OP_READ_TEST:
      begin
        dec.dreg = SIDB_DR_BOUNDARY;
        dec.mode = SIDB_MODE_TEST;
      end
      OP_CELL_SELF_TEST:
      begin
        dec.dreg = SIDB_DR_BOUNDARY;
        dec.cap  = SIDB_CAP_INVERT;
      end
      OP_HIGH_IMPEDANCE:
      begin
        dec.mode     = SIDB_MODE_MOD_TEST;
        dec.io_highz = 1'b1;
      end
      OP_HOLD_CELLS: dec.mode = SIDB_MODE_TEST;
      OP_BOUNDARY_RUN_TEST:
      begin
        dec.mode     = SIDB_MODE_TEST;
        dec.run_test = 1'b1;
      end
      OP_TOGGLE_OUTPUTS:
      begin
        dec.mode       = SIDB_MODE_TEST;
        dec.toggle_out = 1'b1;
      end
      OP_CTRL_SCAN_NORMAL: dec.dreg = SIDB_DR_CONTROL;
      OP_CTRL_SCAN_TEST:
      begin
        dec.dreg = SIDB_DR_CONTROL;
        dec.mode = SIDB_MODE_TEST;
      end
      default: dec.dreg = SIDB_DR_BYPASS;
    endcase
  end

  // test mode hands cells the paths
  assign dec.drive_core = (dec.mode == SIDB_MODE_TEST);
  assign dec.drive_pins = (dec.mode == SIDB_MODE_TEST);

  assign dec.parity_ok = ~(^dec.instr);

endmodule
`default_nettype wire

// ==== core/sidb_pkg.sv ====
// Constants and types for the scan instruction decoder and bypass stage
package sidb_pkg;

  // ********************************
  // Instruction latch
  // ********************************
  localparam int         INSTR_W        = 8;
  localparam logic [7:0] INSTR_RESET    = 8'hFF;
  localparam int         INSTR_PAR_BIT  = 7;

  // ********************************
  // Assigned opcodes, bit 7 down to bit 0
  // ********************************
  localparam logic [7:0] OP_BOUNDARY_EXT       = 8'h00;
  localparam logic [7:0] OP_BOUNDARY_INT       = 8'h03;
  localparam logic [7:0] OP_SAMPLE             = 8'h82;
  localparam logic [7:0] OP_HIGH_IMPEDANCE     = 8'h06;
  localparam logic [7:0] OP_HOLD_CELLS         = 8'h87;
  localparam logic [7:0] OP_BOUNDARY_RUN_TEST  = 8'h09;
  localparam logic [7:0] OP_READ_NORMAL        = 8'h0A;
  localparam logic [7:0] OP_READ_TEST          = 8'h8B;
  localparam logic [7:0] OP_CELL_SELF_TEST     = 8'h0C;
  localparam logic [7:0] OP_TOGGLE_OUTPUTS     = 8'h8D;
  localparam logic [7:0] OP_CTRL_SCAN_NORMAL   = 8'h8E;
  localparam logic [7:0] OP_CTRL_SCAN_TEST     = 8'h0F;

  // ********************************
  // Bypass stage and scan lengths
  // ********************************
  localparam logic       BYPASS_CAPTURE_VAL    = 1'b0;
  localparam int         BYPASS_LEN            = 1;
  localparam int         CONTROL_LEN           = 11;

  // ********************************
  // Decoded selections
  // ********************************
  typedef enum logic [1:0] {
    SIDB_DR_BYPASS   = 2'b00,
    SIDB_DR_BOUNDARY = 2'b01,
    SIDB_DR_CONTROL  = 2'b10
  } sidb_dreg_t;

  typedef enum logic [1:0] {
    SIDB_MODE_NORMAL   = 2'b00,
    SIDB_MODE_TEST     = 2'b01,
    SIDB_MODE_MOD_TEST = 2'b10
  } sidb_mode_t;

  typedef enum logic [1:0] {
    SIDB_CAP_PINS   = 2'b00,
    SIDB_CAP_HOLD   = 2'b01,
    SIDB_CAP_INVERT = 2'b10
  } sidb_cap_t;

endpackage

// ==== core/sidb_scan_decode_top.sv ====
// Instruction latch, bypass stage and mode crossing of the scan test port
`timescale 1ns/1ps
`default_nettype none
module sidb_scan_decode_top
(
  input  wire  logic               sys_clk,
  input  wire  logic               rst_b,
  input  wire  logic               tck,
  input  wire  logic               tap_test_logic_reset,
  input  wire  logic               tap_capture_dr,
  input  wire  logic               tap_shift_dr,
  input  wire  logic               tap_update_ir,
  input  wire  logic [7:0]         instr_shift,
  input  wire  logic               tdi,
  input  wire  logic               boundary_cell_chain_so,
  input  wire  logic               boundary_control_register_so,
  output var   logic               dr_tdo,
  output var   logic               dr_tdo_en,
  output var   sidb_pkg::sidb_dreg_t scan_path_select,
  output var   sidb_pkg::sidb_cap_t  cell_capture_source,
  output var   logic               cell_capture_en,
  output var   logic [7:0]         instruction_latch,
  output var   sidb_pkg::sidb_mode_t device_mode,
  output var   logic               cells_drive_core,
  output var   logic               cells_drive_pins,
  output var   logic               io_release_highz,
  output var   logic               core_function_normal,
  output var   logic               boundary_run_test,
  output var   logic               toggle_outputs_hold_inputs,
  output var   logic               instr_parity_ok,
  output var   logic               mode_changed
);
  import sidb_pkg::*;

  // ********************************
  // Test clock domain reset
  // ********************************

  logic       por_meta_reg;
  logic       por_sync_reg;
  logic       tck_rst;

  // Power-up level brought onto the test clock
  always_ff @(posedge tck)
  begin
    por_meta_reg <= rst_b;
    por_sync_reg <= por_meta_reg;
  end

  // Either source forces the test logic home
  assign tck_rst = ~por_sync_reg | tap_test_logic_reset;

  // ********************************
  // Instruction latch
  // ********************************

  logic [7:0] instruction_latch_reg;
  logic       load_pend_reg;

  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      instruction_latch_reg <= INSTR_RESET;
    end
    else if (tap_update_ir)
    begin
      instruction_latch_reg <= instr_shift;
    end
  end

  // Decode lags the latch by one edge
  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      load_pend_reg <= 1'b1;
    end
    else
    begin
      load_pend_reg <= tap_update_ir;
    end
  end

  // ********************************
  // Decoder
  // ********************************

  sidb_dec_if dec_bus ();

  assign dec_bus.instr = instruction_latch_reg;

  sidb_instr_decoder u_decoder
  (
    .dec (dec_bus.dec)
  );

  // ********************************
  // Decoded hold registers, test clock
  // ********************************

  sidb_dreg_t dreg_reg;
  sidb_cap_t  cap_reg;
  sidb_mode_t mode_hold_reg;
  logic       core_hold_reg;
  logic       pins_hold_reg;
  logic       highz_hold_reg;
  logic       run_hold_reg;
  logic       toggle_hold_reg;
  logic       parity_hold_reg;
  logic       xfer_toggle_reg;

  // refreshed once per update and once after reset, stable otherwise
  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      dreg_reg        <= SIDB_DR_BYPASS;
      cap_reg         <= SIDB_CAP_HOLD;
      mode_hold_reg   <= SIDB_MODE_NORMAL;
      core_hold_reg   <= 1'b0;
      pins_hold_reg   <= 1'b0;
      highz_hold_reg  <= 1'b0;
      run_hold_reg    <= 1'b0;
      toggle_hold_reg <= 1'b0;
      parity_hold_reg <= 1'b0;
    end
    else if (load_pend_reg)
    begin
      dreg_reg        <= dec_bus.dreg;
      cap_reg         <= dec_bus.cap;
      mode_hold_reg   <= dec_bus.mode;
      core_hold_reg   <= dec_bus.drive_core;
      pins_hold_reg   <= dec_bus.drive_pins;
      highz_hold_reg  <= dec_bus.io_highz;
      run_hold_reg    <= dec_bus.run_test;
      toggle_hold_reg <= dec_bus.toggle_out;
      parity_hold_reg <= dec_bus.parity_ok;
    end
  end

  // Event flag for the system side; reset clears it to zero
  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      xfer_toggle_reg <= 1'b0;
    end
    else if (load_pend_reg)
    begin
      xfer_toggle_reg <= ~xfer_toggle_reg;
    end
  end

  // ********************************
  // Bypass stage
  // ********************************

  logic bypass_reg;

  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      bypass_reg <= BYPASS_CAPTURE_VAL;
    end
    else if (dreg_reg == SIDB_DR_BYPASS)
    begin
      if (tap_capture_dr)
      begin
        bypass_reg <= BYPASS_CAPTURE_VAL;
      end
      else if (tap_shift_dr)
      begin
        bypass_reg <= tdi;
      end
    end
  end

  // ********************************
  // Cell capture control, test clock
  // ********************************

  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      cell_capture_source <= SIDB_CAP_HOLD;
      cell_capture_en     <= 1'b0;
    end
    else
    begin
      cell_capture_source <= cap_reg;
      cell_capture_en     <= tap_capture_dr & (dreg_reg == SIDB_DR_BOUNDARY);
    end
  end

  // Path select mirrored as a flop for the chain shifters
  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      scan_path_select <= SIDB_DR_BYPASS;
    end
    else
    begin
      scan_path_select <= dreg_reg;
    end
  end

  // ********************************
  // Serial output, falling edge
  // ********************************

  // Falling edge keeps a half period of setup for the far end
  always_ff @(negedge tck)
  begin
    if (tck_rst)
    begin
      dr_tdo    <= 1'b0;
      dr_tdo_en <= 1'b0;
    end
    else
    begin
      dr_tdo_en <= tap_shift_dr;
      case (dreg_reg)
        SIDB_DR_BYPASS:   dr_tdo <= bypass_reg;
        SIDB_DR_BOUNDARY: dr_tdo <= boundary_cell_chain_so;
        SIDB_DR_CONTROL:  dr_tdo <= boundary_control_register_so;
        default:          dr_tdo <= bypass_reg;
      endcase
    end
  end

  // ********************************
  // Crossing to the system clock
  // ********************************

  logic xfer_meta_reg;
  logic xfer_sync_reg;
  logic xfer_last_reg;
  logic xfer_seen;

  // Toggle synchroniser; only the second stage and its delayed copy are looked at
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      xfer_meta_reg <= 1'b0;
      xfer_sync_reg <= 1'b0;
      xfer_last_reg <= 1'b0;
    end
    else
    begin
      xfer_meta_reg <= xfer_toggle_reg;
      xfer_sync_reg <= xfer_meta_reg;
      xfer_last_reg <= xfer_sync_reg;
    end
  end

  // Hold words are stable for several test clocks after a flip
  assign xfer_seen = xfer_sync_reg ^ xfer_last_reg;

  // ********************************
  // Mode outputs, system clock
  // ********************************

  // mode changes only when a toggle flip is seen, update or reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      device_mode                <= SIDB_MODE_NORMAL;
      cells_drive_core           <= 1'b0;
      cells_drive_pins           <= 1'b0;
      io_release_highz           <= 1'b0;
      core_function_normal       <= 1'b1;
      boundary_run_test          <= 1'b0;
      toggle_outputs_hold_inputs <= 1'b0;
      instr_parity_ok            <= 1'b0;
    end
    else if (xfer_seen)
    begin
      device_mode                <= mode_hold_reg;
      cells_drive_core           <= core_hold_reg;
      cells_drive_pins           <= pins_hold_reg;
      io_release_highz           <= highz_hold_reg;
      core_function_normal       <= ~core_hold_reg;
      boundary_run_test          <= run_hold_reg;
      toggle_outputs_hold_inputs <= toggle_hold_reg;
      instr_parity_ok            <= parity_hold_reg;
    end
  end

  // Active instruction copy, sampled with the same event
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      instruction_latch <= INSTR_RESET;
    end
    else if (xfer_seen)
    begin
      instruction_latch <= instruction_latch_reg;
    end
  end

  // One-cycle pulse per accepted update
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mode_changed <= 1'b0;
    end
    else
    begin
      mode_changed <= xfer_seen;
    end
  end

endmodule
`default_nettype wire

// ==== test/sidb_scan_decode_top_bench.sv ====
// Self-checking bench for the scan instruction decoder and bypass stage
`timescale 1ns/1ps
`default_nettype none
module sidb_scan_decode_top_bench;
  import sidb_pkg::*;
  logic sys_clk, rst_b, tck, tlr, cap, sh, upd, tdi, cso, kso, tdo, tdo_en;
  logic ccap_en, drvc, drvp, hz, cnorm, rt, tog, par, mchg;
  logic [7:0] ishift, ilatch;
  sidb_dreg_t sel;
  sidb_cap_t  csrc;
  sidb_mode_t mode;
  int bad_count = 0;
  int checks = 0;
  // Op in 14:8, path 5:4, mode 3:2, capture source 1:0
  logic [15:0] tab [18] = '{16'h0014, 16'h0314, 16'h0210, 16'h0609, 16'h0705, 16'h0905, 16'h0A11, 16'h0B15,
    16'h0C12, 16'h0D05, 16'h0E21, 16'h0F25, 16'h0101, 16'h0401, 16'h0501, 16'h0801, 16'h7F01, 16'h5001};

  // ****
  // Clock, model and design
  // ****
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  sidb_tap_model sidb_tap_model_inst (.tck(tck), .tap_test_logic_reset(tlr), .tap_capture_dr(cap),
    .tap_shift_dr(sh), .tap_update_ir(upd), .instr_shift(ishift), .tdi(tdi), .chain_so(cso), .ctrl_so(kso),
    .dr_tdo(tdo), .dr_tdo_en(tdo_en));
  sidb_scan_decode_top sidb_scan_decode_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .tck(tck),
    .tap_test_logic_reset(tlr), .tap_capture_dr(cap), .tap_shift_dr(sh), .tap_update_ir(upd),
    .instr_shift(ishift), .tdi(tdi), .boundary_cell_chain_so(cso), .boundary_control_register_so(kso),
    .dr_tdo(tdo), .dr_tdo_en(tdo_en), .scan_path_select(sel), .cell_capture_source(csrc),
    .cell_capture_en(ccap_en), .instruction_latch(ilatch), .device_mode(mode), .cells_drive_core(drvc),
    .cells_drive_pins(drvp), .io_release_highz(hz), .core_function_normal(cnorm), .boundary_run_test(rt),
    .toggle_outputs_hold_inputs(tog), .instr_parity_ok(par), .mode_changed(mchg));

  // ****
  // Compare and verdict
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk("latch", 8'hFF, ilatch); // Reset value
    chk("mode", SIDB_MODE_NORMAL, mode); // Reset mode
    chk("core", 1'b1, cnorm); // Core untouched
    chk("path", SIDB_DR_BYPASS, sel); // Reset path
  endtask
  // Every listed and some unlisted opcodes, each followed by a short scan
  task automatic t_decode();
    logic [7:0] op;
    logic [1:0] got;
    logic en;
    for (int i = 0; i < 18; i++)
    begin
      op = {^tab[i][14:8], tab[i][14:8]};
      sidb_tap_model_inst.load_ir(tab[i][14:8]);
      chk("path", tab[i][5:4], sel); // Table path
      chk("mode", tab[i][3:2], mode); // Table mode
      chk("capsrc", tab[i][1:0], csrc); // Capture source
      chk("latch", op, ilatch); // Active code
      chk("parity", 1'b1, par); // Even code
      chk("drive", {{2{tab[i][3:2] == 2'b01}}, tab[i][3:2] != 2'b01}, {drvc, drvp, cnorm}); // Cells
      chk("flags", {op == 8'h06, op == 8'h09, op == 8'h8D}, {hz, rt, tog}); // Mode flags
      sidb_tap_model_inst.scan(1'b1, got, en);
      chk("scan", {tab[i][5:4] == 2'b01, tab[i][5:4] != 2'b10}, got); // Path bits
      chk("tdo_en", 1'b1, en); // Output enabled in shift
    end
  endtask
  // Odd-parity codes are flagged and fall to bypass, not to their even twin
  task automatic t_parity();
    sidb_tap_model_inst.load_raw(8'h02);
    chk("path", SIDB_DR_BYPASS, sel); // Odd sample code
    chk("mode", SIDB_MODE_NORMAL, mode); // Normal mode
    chk("parity", 1'b0, par); // Odd count flagged
    sidb_tap_model_inst.load_raw(8'h80);
    chk("path", SIDB_DR_BYPASS, sel); // Odd boundary code
    chk("latch", 8'h80, ilatch); // Active code
    chk("parity", 1'b0, par); // Odd count flagged
  endtask
  task automatic t_hold();
    sidb_tap_model_inst.load_ir(7'h00);
    sidb_tap_model_inst.shift_only();
    chk("path", SIDB_DR_BOUNDARY, sel); // Shifter ignored
    chk("mode", SIDB_MODE_TEST, mode); // Held mode
    chk("latch", 8'h00, ilatch); // Held code
  endtask
  task automatic t_tlr();
    logic [1:0] got;
    logic en;
    sidb_tap_model_inst.tlr(3);
    chk("path", SIDB_DR_BYPASS, sel); // Logic reset
    sidb_tap_model_inst.scan(1'b1, got, en);
    chk("scan", 2'b01, got); // Zero then data
    chk("mode", SIDB_MODE_NORMAL, mode); // Logic reset mode
    chk("latch", 8'hFF, ilatch); // Logic reset code
  endtask

  // ****
  // Main sequence and watchdog
  // ****
  initial
  begin
    rst_b = 1'b0;
    fork
      sidb_tap_model_inst.tlr(6);
      begin
        repeat (16) @(posedge sys_clk);
        #1 rst_b = 1'b1;
      end
    join
    @(posedge sys_clk);
    #1;
    t_reset();
    t_decode();
    t_parity();
    t_hold();
    t_tlr();
    results();
  end
  // About 153 test clock periods are needed; allow five times that
  initial
  begin
    #50000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire

// ==== test/sidb_scan_props.sv ====
// Concurrent checks on the scan decode ports
`timescale 1ns/1ps
`default_nettype none
module sidb_scan_props
(
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  input wire logic                 tck,
  input wire logic                 tap_test_logic_reset,
  input wire logic                 tap_capture_dr,
  input wire logic                 tap_shift_dr,
  input wire logic                 tap_update_ir,
  input wire logic [7:0]           instr_shift,
  input wire logic                 tdi,
  input wire logic                 dr_tdo,
  input wire sidb_pkg::sidb_dreg_t scan_path_select,
  input wire logic                 cell_capture_en,
  input wire logic [7:0]           instruction_latch,
  input wire sidb_pkg::sidb_mode_t device_mode,
  input wire logic                 cells_drive_core,
  input wire logic                 io_release_highz,
  input wire logic                 core_function_normal,
  input wire logic                 boundary_run_test,
  input wire logic                 mode_changed
);
  import sidb_pkg::*;
  // ****
  // Test clock domain
  // ****
  sequence s_upd(logic [7:0] op);
    tap_update_ir && instr_shift == op;
  endsequence
  sequence s_cap_bypass;
    tap_capture_dr && scan_path_select == SIDB_DR_BYPASS;
  endsequence

  a_boundary_ext_sel: assert property (@(posedge tck) disable iff (!rst_b || tap_test_logic_reset)
    s_upd(8'h00) |-> ##[2:4] scan_path_select == SIDB_DR_BOUNDARY) else $error("boundary not selected");
  a_ctrl_reg_sel: assert property (@(posedge tck) disable iff (!rst_b || tap_test_logic_reset)
    s_upd(8'h8E) |-> ##[2:4] scan_path_select == SIDB_DR_CONTROL) else $error("control not selected");
  a_reserved_bypass: assert property (@(posedge tck) disable iff (!rst_b || tap_test_logic_reset)
    s_upd(8'h81) |-> ##[2:4] scan_path_select == SIDB_DR_BYPASS) else $error("reserved not bypass");
  a_bypass_zero: assert property (@(posedge tck) disable iff (!rst_b || tap_test_logic_reset)
    s_cap_bypass |=> dr_tdo == 1'b0) else $error("bypass capture not zero");
  a_bypass_one_bit: assert property (@(posedge tck) disable iff (!rst_b || tap_test_logic_reset)
    tap_shift_dr && scan_path_select == SIDB_DR_BYPASS |=> dr_tdo == $past(tdi)) else $error("bypass not one bit");
  a_cell_capture: assert property (@(posedge tck) disable iff (!rst_b || tap_test_logic_reset)
    tap_capture_dr && scan_path_select == SIDB_DR_BOUNDARY |-> ##[1:2] cell_capture_en) else $error("no cell capture");
  a_tlr_bypass: assert property (@(posedge tck) disable iff (!rst_b)
    tap_test_logic_reset |=> scan_path_select == SIDB_DR_BYPASS) else $error("reset not bypass");
  // ****
  // System clock domain
  // ****
  a_core_normal: assert property (@(posedge sys_clk) disable iff (!rst_b)
    core_function_normal == !cells_drive_core && cells_drive_core == (device_mode == SIDB_MODE_TEST))
    else $error("core function mismatch");
  a_highz_mod: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_release_highz == (device_mode == SIDB_MODE_MOD_TEST)) else $error("release outside modified test");
  a_mode_update: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $changed(device_mode) |-> mode_changed) else $error("mode moved without update");
  a_runtest_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    boundary_run_test |-> device_mode == SIDB_MODE_TEST && instruction_latch == 8'h09) else $error("run test flag");
endmodule
bind sidb_scan_decode_top sidb_scan_props sidb_scan_props_inst (.sys_clk, .rst_b, .tck, .tap_test_logic_reset,
  .tap_capture_dr, .tap_shift_dr, .tap_update_ir, .instr_shift, .tdi, .dr_tdo, .scan_path_select, .cell_capture_en,
  .instruction_latch, .device_mode, .cells_drive_core, .io_release_highz, .core_function_normal,
  .boundary_run_test, .mode_changed);
`default_nettype wire

// ==== test/sidb_tap_model.sv ====
// Scan test controller model driving the test port
`timescale 1ns/1ps
`default_nettype none
module sidb_tap_model
(
  output var logic       tck,
  output var logic       tap_test_logic_reset,
  output var logic       tap_capture_dr,
  output var logic       tap_shift_dr,
  output var logic       tap_update_ir,
  output var logic [7:0] instr_shift,
  output var logic       tdi,
  output var logic       chain_so,
  output var logic       ctrl_so,
  input  wire logic      dr_tdo,
  input  wire logic      dr_tdo_en
);
  // ****
  // Idle levels; distinct chain outputs tell the paths apart
  // ****
  initial
  begin
    tck = 1'b0;
    tap_test_logic_reset = 1'b1;
    tap_capture_dr = 1'b0;
    tap_shift_dr = 1'b0;
    tap_update_ir = 1'b0;
    instr_shift = 8'hFF;
    tdi = 1'b0;
    chain_so = 1'b1;
    ctrl_so = 1'b0;
  end

  // One test clock period; the clock stands high between frames
  task automatic cyc();
    #29 tck = 1'b0;
    #32 tck = 1'b1;
    #3;
  endtask

  // Hold the port in test-logic reset for n periods
  task automatic tlr(input int n);
    tap_test_logic_reset = 1'b1;
    repeat (n) cyc();
    tap_test_logic_reset = 1'b0;
  endtask

  // Update with any byte, odd parity included
  task automatic load_raw(input logic [7:0] v);
    instr_shift = v;
    tap_update_ir = 1'b1;
    cyc();
    tap_update_ir = 1'b0;
    repeat (3) cyc();
  endtask

  task automatic load_ir(input logic [6:0] op);
    load_raw({^op, op});
  endtask

  // Shifter moves without an update
  task automatic shift_only();
    instr_shift = ~instr_shift;
    repeat (3) cyc();
  endtask

  // Capture, then two shift bits; serial out only read while enabled
  task automatic scan(input logic d, output logic [1:0] got, output logic en);
    tap_capture_dr = 1'b1;
    cyc();
    tap_capture_dr = 1'b0;
    tap_shift_dr = 1'b1;
    tdi = d;
    cyc();
    got[1] = dr_tdo;
    en = dr_tdo_en;
    tdi = ~d;
    cyc();
    got[0] = dr_tdo;
    en = en & dr_tdo_en;
    tap_shift_dr = 1'b0;
  endtask
endmodule
`default_nettype wire
